// File: design/counter_array.v
// Purpose: Counter array with one shared 16-bit time base and five compare/capture modules.
// Assumes: APB slave on mclk; pins pass two flip-flops before use.
// Notes on behaviour
// - Counter clock chosen by two-bit select.
// - One shared counter feeds five modules.
// - Modules capture, compare, toggle or modulate.
// - Watchdog enable bit gates module four watchdog.
// - Idle-stop bit halts counter during idle.
// - Counter runs only while run bit set.
// - Overflow sets sticky flag, optional interrupt.
// - Match or capture sets module flag.
// - All sources share one interrupt output.
// - Count input and module pins on port.
// - Compare plus match enable flags matches.
// - Low byte write clears, high sets compare.
// - Output low below duty byte, else high.
// - Duty byte reloads when low byte wraps.
// - Modulation needs modulate and compare bits.
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`include "counter_array_consts.vh"
module counter_array
(
	input wire mclk,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire double_speed_mode,
	input wire timer0_overflow,
	input wire cpu_idle,
	input wire external_count_input,
	input wire [4:0] module_pin_in,
	output reg [4:0] module_pin_out,
	output reg [4:0] module_pin_oe,
	output reg watchdog_reset,
	output reg irq
);
// ************************************************
// Declarations.
// ************************************************
reg [1:0] eci_sync;
reg [4:0] pin_s1;
reg [4:0] pin_s2;
reg eci_last;
reg [7:0] array_mode_register;
reg overflow_flag;
reg run_control_bit;
reg [4:0] module_flag;
reg [15:0] count;
reg [3:0] prescale;
reg tick;
reg next_tick;
reg [3:0] div_limit;
reg [31:0] next_rdata;
reg next_err;
wire [34:0] mod_mode_bus;
wire [39:0] mod_lo_bus;
wire [39:0] mod_hi_bus;
wire [4:0] mod_event;
wire [4:0] mod_out;
wire [4:0] mod_oe;
wire access;
wire wr;
wire is_mod;
wire [2:0] mod_idx;
wire [1:0] mod_reg;
wire counting;
wire [4:0] flag_clear;
wire ctl_wr;
wire mode_wr;
wire wrap;
wire [1:0] clk_sel;
wire [4:0] mod_irq_en;
wire [7:0] mod_sel;
wire [4:0] mod_wr_mode;
wire [4:0] mod_wr_lo;
wire [4:0] mod_wr_hi;
wire mod_ok;
wire wdog_hit;
wire ovf_irq;
// ************************************************
// Bus strobes and shared terms.
// ************************************************
assign access = psel & penable & pready;
assign wr = access & pwrite;
assign is_mod = (paddr <= `MOD_LAST_ADDR) & (paddr[1:0] == 2'h0);
assign mod_idx = paddr[6:4];
assign mod_reg = paddr[3:2];
assign ctl_wr = wr & (paddr == `OFF_CONTROL);
assign mode_wr = wr & (paddr == `OFF_MODE);
assign counting = run_control_bit & ~(array_mode_register[`BIT_IDLE_STOP] & cpu_idle);
assign flag_clear = ctl_wr ? ~pwdata[4:0] : 5'h00;
assign wrap = tick & (count == 16'hFFFF);
assign clk_sel = {array_mode_register[`FLD_CLKSEL_HI], array_mode_register[`FLD_CLKSEL_LO]};
assign mod_irq_en = {mod_mode_bus[28], mod_mode_bus[21], mod_mode_bus[14], mod_mode_bus[7],
	mod_mode_bus[0]};
assign mod_ok = is_mod & (mod_idx < 3'h5);
assign wdog_hit = array_mode_register[`BIT_WDOG_EN] & mod_event[4];
assign ovf_irq = overflow_flag & array_mode_register[`BIT_OVF_IE];
// ************************************************
// Module write strobes.
// ************************************************
assign mod_sel = 8'h01 << mod_idx;
assign mod_wr_mode = (wr & is_mod & (mod_reg == `MOD_MODE)) ? mod_sel[4:0] : 5'h00;
assign mod_wr_lo = (wr & is_mod & (mod_reg == `MOD_CMP_LO)) ? mod_sel[4:0] : 5'h00;
assign mod_wr_hi = (wr & is_mod & (mod_reg == `MOD_CMP_HI)) ? mod_sel[4:0] : 5'h00;
// ************************************************
// Pin synchronisers.
// ************************************************
always @(posedge mclk or negedge nrst)
begin
	if (!nrst)
	begin
		eci_sync <= 2'h0;
		pin_s1 <= 5'h00;
		pin_s2 <= 5'h00;
		eci_last <= 1'b0;
	end
	else
	begin
		eci_sync <= {eci_sync[0], external_count_input};
		pin_s1 <= module_pin_in;
		pin_s2 <= pin_s1;
		eci_last <= eci_sync[1];
	end
end
// ************************************************
// Count source selection.
// ************************************************
always @*
begin
	div_limit = `DIV_SLOW;
	next_tick = 1'b0;
	case (clk_sel)
		2'h0:
		begin
			div_limit = double_speed_mode ? `DIV_SLOW_X2 : `DIV_SLOW;
			next_tick = counting & (prescale == div_limit);
		end
		2'h1:
		begin
			div_limit = double_speed_mode ? `DIV_FAST_X2 : `DIV_FAST;
			next_tick = counting & (prescale == div_limit);
		end
		2'h2:
			next_tick = counting & timer0_overflow;
		default:
			next_tick = counting & eci_sync[1] & ~eci_last;
	endcase
end
// ************************************************
// Prescaler and shared counter.
// ************************************************
always @(posedge mclk or negedge nrst)
begin
	if (!nrst)
	begin
		prescale <= 4'h0;
		tick <= 1'b0;
		count <= 16'h0000;
	end
	else
	begin
		if (!counting || prescale >= div_limit)
			prescale <= 4'h0;
		else
			prescale <= prescale + 4'h1;
		tick <= next_tick;
		if (tick)
			count <= count + 16'h0001;
	end
end
// ************************************************
// Mode register.
// ************************************************
always @(posedge mclk or negedge nrst)
begin
	if (!nrst)
		array_mode_register <= `MODE_RESET;
	else if (mode_wr)
		array_mode_register <= pwdata[7:0] & 8'hC7;
end
// ************************************************
// Control register.
// ************************************************
always @(posedge mclk or negedge nrst)
begin
	if (!nrst)
	begin
		overflow_flag <= 1'b0;
		run_control_bit <= 1'b0;
		module_flag <= 5'h00;
	end
	else
	begin
		if (ctl_wr)
			run_control_bit <= pwdata[`BIT_RUN];
		if (wrap)
			overflow_flag <= 1'b1;
		else if (ctl_wr & ~pwdata[`BIT_OVF])
			overflow_flag <= 1'b0;
		module_flag <= (module_flag & ~flag_clear) | mod_event;
	end
end
// ************************************************
// Registered outputs.
// ************************************************
always @(posedge mclk or negedge nrst)
begin
	if (!nrst)
	begin
		watchdog_reset <= 1'b0;
		irq <= 1'b0;
		module_pin_out <= 5'h00;
		module_pin_oe <= 5'h00;
	end
	else
	begin
		watchdog_reset <= wdog_hit;
		irq <= ovf_irq | (|(module_flag & mod_irq_en));
		module_pin_out <= mod_out;
		module_pin_oe <= mod_oe;
	end
end
// ************************************************
// Five compare/capture modules.
// ************************************************
genvar gi;
generate
	for (gi = 0; gi < 5; gi = gi + 1)
	begin : g_mod
		capture_compare_module u_mod
		(
			.mclk(mclk),
			.nrst(nrst),
			.tick(tick),
			.count(count),
			.pin_in(pin_s2[gi]),
			.wr_mode(mod_wr_mode[gi]),
			.wr_lo(mod_wr_lo[gi]),
			.wr_hi(mod_wr_hi[gi]),
			.wdata(pwdata[7:0]),
			.mode(mod_mode_bus[gi*7 +: 7]),
			.cmp_lo(mod_lo_bus[gi*8 +: 8]),
			.cmp_hi(mod_hi_bus[gi*8 +: 8]),
			.event_set(mod_event[gi]),
			.pin_out(mod_out[gi]),
			.pin_oe(mod_oe[gi])
		);
	end
endgenerate
// ************************************************
// APB read decode.
// ************************************************
always @*
begin
	next_rdata = 32'h00000000;
	next_err = 1'b0;
	if (paddr == `OFF_CONTROL)
		next_rdata = {24'h000000, overflow_flag, run_control_bit, 1'b0, module_flag};
	else if (paddr == `OFF_MODE)
		next_rdata = {24'h000000, array_mode_register};
	else if (paddr == `OFF_COUNT_LO)
		next_rdata = {24'h000000, count[7:0]};
	else if (paddr == `OFF_COUNT_HI)
		next_rdata = {24'h000000, count[15:8]};
	else if (mod_ok & (mod_reg == `MOD_MODE))
		next_rdata = {25'h0000000, mod_mode_bus[mod_idx*7 +: 7]};
	else if (mod_ok & (mod_reg == `MOD_CMP_LO))
		next_rdata = {24'h000000, mod_lo_bus[mod_idx*8 +: 8]};
	else if (mod_ok & (mod_reg == `MOD_CMP_HI))
		next_rdata = {24'h000000, mod_hi_bus[mod_idx*8 +: 8]};
	else
		next_err = 1'b1;
end
// ************************************************
// APB response.
// ************************************************
always @(posedge mclk or negedge nrst)
begin
	if (!nrst)
	begin
		pready <= 1'b0;
		prdata <= 32'h00000000;
		pslverr <= 1'b0;
	end
	else
	begin
		pready <= psel & ~penable;
		pslverr <= psel & ~penable & next_err;
		if (psel & ~penable & ~pwrite)
			prdata <= next_rdata;
	end
end
endmodule // counter_array

// File: design/counter_array_consts.vh
// Purpose: Offsets, field positions, reset values and timing counts of the counter array.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Every offset printed is a byte address.
`ifndef COUNTER_ARRAY_CONSTS_VH
`define COUNTER_ARRAY_CONSTS_VH
`define OFF_CONTROL 8'hD8
`define OFF_MODE 8'hDC
`define OFF_COUNT_LO 8'hE0
`define OFF_COUNT_HI 8'hE4
`define OFF_MOD_BASE 8'h00
`define MOD_STRIDE_SH 4
`define MOD_MODE 2'h0
`define MOD_CMP_LO 2'h1
`define MOD_CMP_HI 2'h2
`define MOD_LAST_ADDR 8'h4C
`define BIT_OVF 7
`define BIT_RUN 6
`define BIT_IDLE_STOP 7
`define BIT_WDOG_EN 6
`define BIT_OVF_IE 0
`define FLD_CLKSEL_HI 2
`define FLD_CLKSEL_LO 1
`define MM_COMPARE 6
`define MM_CAP_POS 5
`define MM_CAP_NEG 4
`define MM_MATCH 3
`define MM_TOGGLE 2
`define MM_PWM 1
`define MM_IRQ_EN 0
`define CONTROL_RESET 8'h00
`define MODE_RESET 8'h00
`define MMODE_RESET 7'h00
`define DIV_SLOW 4'hB
`define DIV_SLOW_X2 4'h5
`define DIV_FAST 4'h3
`define DIV_FAST_X2 4'h1
`endif

// File: design/capture_compare_module.v
// Purpose: One compare/capture module of the counter array.
// Assumes: Counter value and tick come from the shared time base.
// Notes: The pin input arrives already synchronised.
`timescale 1ns/100ps
`include "counter_array_consts.vh"
module capture_compare_module
(
	input wire mclk,
	input wire nrst,
	input wire tick,
	input wire [15:0] count,
	input wire pin_in,
	input wire wr_mode,
	input wire wr_lo,
	input wire wr_hi,
	input wire [7:0] wdata,
	output reg [6:0] mode,
	output reg [7:0] cmp_lo,
	output reg [7:0] cmp_hi,
	output reg event_set,
	output reg pin_out,
	output reg pin_oe
);
reg pin_last;
wire [7:0] next_lo;
wire [7:0] next_hi;
wire cmp_on;
wire pwm_on;
wire hit;
wire cap_edge;
assign cmp_on = mode[`MM_COMPARE];
assign pwm_on = mode[`MM_PWM] & cmp_on;
assign hit = cmp_on & mode[`MM_MATCH] & tick & (count == {cmp_hi, cmp_lo});
assign cap_edge = (mode[`MM_CAP_POS] & pin_in & ~pin_last) |
	(mode[`MM_CAP_NEG] & ~pin_in & pin_last);
assign next_lo = wr_lo ? wdata : cmp_lo;
assign next_hi = wr_hi ? wdata : cmp_hi;
// ************************************************
// Mode, compare and capture registers.
// ************************************************
always @(posedge mclk or negedge nrst)
begin
	if (!nrst)
	begin
		mode <= `MMODE_RESET;
		cmp_lo <= 8'h00;
		cmp_hi <= 8'h00;
		pin_last <= 1'b0;
		event_set <= 1'b0;
		pin_out <= 1'b0;
		pin_oe <= 1'b0;
	end
	else
	begin
		pin_last <= pin_in;
		event_set <= hit | (cap_edge & ~cmp_on);
		if (wr_mode)
			mode <= wdata[6:0];
		else if (wr_lo)
			mode[`MM_COMPARE] <= 1'b0;
		else if (wr_hi)
			mode[`MM_COMPARE] <= 1'b1;
		if (cap_edge & ~cmp_on)
		begin
			cmp_lo <= count[7:0];
			cmp_hi <= count[15:8];
		end
		else if (pwm_on & tick & (count[7:0] == 8'hFF))
		begin
			cmp_lo <= cmp_hi;
			cmp_hi <= next_hi;
		end
		else
		begin
			cmp_lo <= next_lo;
			cmp_hi <= next_hi;
		end
		pin_oe <= pwm_on | (cmp_on & mode[`MM_TOGGLE]);
		if (pwm_on)
			pin_out <= (count[7:0] >= cmp_lo);
		else if (hit & mode[`MM_TOGGLE])
			pin_out <= ~pin_out;
	end
end
endmodule // capture_compare_module

// File: sim/counter_array_props.sv
// Purpose: Bus protocol checks on the counter array ports.
// Assumes: Wait-free slave, one pready cycle per access.
// Notes: Attached by bind below.
`timescale 1ns/100ps
module counter_array_props
(
	input wire mclk,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire rd = pready && !pwrite;
	wire known = paddr == 8'hD8 || paddr == 8'hDC || paddr == 8'hE0 || paddr == 8'hE4;
	a_ready_setup: assert property (psel && !penable && !pready |=> pready)
		else $error("pready late");
	a_ready_once: assert property (pready |=> !pready) else $error("pready held");
	a_ready_phase: assert property (pready |-> psel && penable) else $error("stray pready");
	a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
	a_err_rdzero: assert property (pslverr && rd |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_err_high: assert property (pready && paddr > 8'hE4 |-> pslverr)
		else $error("unmapped not refused");
	a_err_none: assert property (pready && known |-> !pslverr) else $error("mapped refused");
	a_read_byte: assert property (rd && known |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	c_write: cover property (pready && pwrite);
	c_read: cover property (rd && known);
	c_error: cover property (pslverr);
endmodule // counter_array_props
bind counter_array counter_array_props u_props (.mclk(mclk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));

// File: sim/pin_side.sv
// Purpose: Port pins and timer source outside the counter array.
// Assumes: Pins pulled high unless driven.
// Notes: Count sources run only while run is high.
`timescale 1ns/100ps
module pin_side
(
	input wire mclk,
	input wire run,
	input wire [4:0] pin_out,
	input wire [4:0] pin_oe,
	input wire [4:0] drive,
	output wire [4:0] pin_level,
	output reg timer0_overflow,
	output reg ext_count
);
	reg [1:0] ph;
	// The array wins a pin only while it enables it.
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & drive);
	initial
	begin
		ph = 2'h0;
		timer0_overflow = 1'b0;
		ext_count = 1'b0;
	end
	always @(posedge mclk)
	begin
		ph <= ph + {1'b0, run};
		timer0_overflow <= run && ph[0];
		ext_count <= ph[1];
	end
endmodule // pin_side

// File: sim/testbench.sv
// Purpose: Self-checking bench of the counter array.
// Assumes: APB master at the rising edge.
// Notes: Counts are judged as moving or standing.
`timescale 1ns/100ps
module testbench;
	reg mclk, nrst, psel, penable, pwrite, idle, run, err;
	reg [7:0] paddr;
	reg [31:0] pwdata, rd, c0;
	reg [4:0] drive;
	reg [1:0] seen;
	wire [31:0] prdata;
	wire pready, pslverr, irq, wdog, t0, ecnt;
	wire [4:0] pout, poe, plev;
	integer n_errors, comparisons, cycles, i;
	counter_array uut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .double_speed_mode(1'b0), .timer0_overflow(t0), .cpu_idle(idle),
		.external_count_input(ecnt), .module_pin_in(plev), .module_pin_out(pout),
		.module_pin_oe(poe), .watchdog_reset(wdog), .irq(irq));
	pin_side partner (.mclk(mclk), .run(run), .pin_out(pout), .pin_oe(poe), .drive(drive),
		.pin_level(plev), .timer0_overflow(t0), .ext_count(ecnt));
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles = cycles + 1;
		if (cycles == 30000)
		begin
			n_errors = n_errors + 1;
			finish_test;
		end
	end
	task finish_test;
	begin
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
	begin
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			n_errors = n_errors + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		integer k;
	begin
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		@(posedge mclk);
		while (pready !== 1'b1)
		begin
			k = k + 1;
			@(posedge mclk);
		end
		rd = prdata;
		err = pslverr;
		chk(k, 0);
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask
	task t_reset;
	begin
		apb(0, 8'hD8, 0);
		chk(rd, 32'h0);
		chk({irq, wdog, poe, pout}, 32'h0);
		apb(0, 8'hDC, 0);
		chk(rd, 32'h0);
		apb(0, 8'hF0, 0);
		chk({err, rd[30:0]}, 32'h80000000);
	end
	endtask
	task t_count;
	begin
		run <= 1'b1;
		for (i = 0; i < 4; i = i + 1)
		begin
			apb(1, 8'hDC, i << 1);
			apb(0, 8'hE0, 0);
			c0 = rd;
			apb(1, 8'hD8, 32'h40);
			repeat (100) @(posedge mclk);
			apb(1, 8'hD8, 32'h0);
			apb(0, 8'hE0, 0);
			chk(rd !== c0, 1);
			c0 = rd;
			repeat (20) @(posedge mclk);
			apb(0, 8'hE0, 0);
			chk(rd, c0);
		end
		apb(1, 8'hDC, 32'h82);
		idle <= 1'b1;
		apb(1, 8'hD8, 32'h40);
		apb(0, 8'hE0, 0);
		c0 = rd;
		repeat (40) @(posedge mclk);
		apb(0, 8'hE0, 0);
		chk(rd, c0);
		idle <= 1'b0;
		apb(1, 8'hDC, 32'h02);
	end
	endtask
	task t_compare;
	begin
		apb(1, 8'h00, 32'h49);
		apb(1, 8'h04, 32'hF0);
		apb(0, 8'h00, 0);
		chk(rd, 32'h09);
		apb(1, 8'h08, 32'h00);
		apb(0, 8'h00, 0);
		chk(rd, 32'h49);
		for (i = 0; i < 1500 && irq !== 1'b1; i = i + 1)
			@(posedge mclk);
		chk(irq, 1);
		apb(0, 8'hD8, 0);
		chk(rd, 32'h41);
		apb(1, 8'hD8, 32'h40);
		apb(0, 8'hD8, 0);
		chk(rd, 32'h40);
		chk(irq, 0);
	end
	endtask
	task t_capture;
	begin
		apb(1, 8'hD8, 32'h00);
		apb(1, 8'h10, 32'h20);
		apb(0, 8'hE0, 0);
		c0 = rd;
		apb(0, 8'hE4, 0);
		c0 = {16'h0000, rd[7:0], c0[7:0]};
		drive[1] <= 1'b0;
		repeat (4) @(posedge mclk);
		drive[1] <= 1'b1;
		repeat (8) @(posedge mclk);
		apb(0, 8'hD8, 0);
		chk(rd, 32'h02);
		apb(0, 8'h14, 0);
		chk(rd, {24'h000000, c0[7:0]});
		apb(0, 8'h18, 0);
		chk(rd, {24'h000000, c0[15:8]});
	end
	endtask
	task t_pwm;
	begin
		apb(1, 8'hD8, 32'h40);
		apb(1, 8'h24, 32'h00);
		apb(1, 8'h28, 32'h80);
		apb(1, 8'h20, 32'h42);
		seen = 2'b00;
		repeat (2200)
		begin
			@(posedge mclk);
			seen[pout[2]] = 1'b1;
		end
		chk(poe[2], 1);
		chk(seen, 2'b11);
		chk(plev[2], pout[2]);
	end
	endtask
	task t_watchdog;
	begin
		apb(1, 8'hDC, 32'h42);
		apb(1, 8'hD8, 32'h40);
		apb(0, 8'hE0, 0);
		c0 = rd;
		apb(0, 8'hE4, 0);
		c0 = {16'h0000, rd[7:0], c0[7:0]} + 32'h00000040;
		apb(1, 8'h44, {24'h000000, c0[7:0]});
		apb(1, 8'h48, {24'h000000, c0[15:8]});
		apb(1, 8'h40, 32'h48);
		for (i = 0; i < 2000 && wdog !== 1'b1; i = i + 1)
			@(posedge mclk);
		chk(wdog, 1);
		apb(0, 8'hD8, 0);
		chk(rd, 32'h50);
	end
	endtask
	initial
	begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		idle = 1'b0;
		run = 1'b0;
		drive = 5'h1F;
		n_errors = 0;
		comparisons = 0;
		cycles = 0;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		t_reset;
		t_count;
		t_compare;
		t_capture;
		t_pwm;
		t_watchdog;
		finish_test;
	end
endmodule // testbench
